// ==== hw/asp_pkg.sv ====
/*
 * Package for the sample post-processor: format codes, widths, reset values.
 * Assumes a single 100 MHz clock domain shared by all users.
 */
package asp_pkg;
    // ----------------------------------------
    // Output format codes
    // ----------------------------------------
    localparam logic [2:0] ASP_FMT_DIFF24 = 3'h0;
    localparam logic [2:0] ASP_FMT_D16CM = 3'h1;
    localparam logic [2:0] ASP_FMT_D24CM = 3'h2;
    localparam logic [2:0] ASP_FMT_AVG = 3'h3;
    localparam logic [2:0] ASP_FMT_TEST = 3'h4;

    // ----------------------------------------
    // Widths and limits
    // ----------------------------------------
    localparam int ASP_DW = 24;
    localparam int ASP_AVG_W = 30;
    localparam int ASP_ACC_W = 40;
    localparam logic [4:0] ASP_AVG_MAX = 5'h10;
    localparam logic [23:0] ASP_POS_MAX = 24'h7F_FFFF;
    localparam logic [23:0] ASP_NEG_MAX = 24'h80_0000;
    localparam int ASP_GAIN_SHIFT = 15;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [4:0] ASP_AVG_RST = 5'h00;
    localparam logic [23:0] ASP_OFFSET_RST = 24'h00_0000;
    localparam logic [15:0] ASP_GAIN_RST = 16'h8000;
    localparam logic [31:0] ASP_PATTERN_RST = 32'h5A5A_0F0F;
    localparam logic [16:0] ASP_CNT_RST = 17'h0_0000;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [23:0] diff;
        logic [7:0] cm;
        logic sat;
    } asp_raw_s;

    typedef struct packed {
        logic [31:0] word;
        logic update;
    } asp_out_s;
endpackage

// ==== hw/asp_skid.sv ====
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module asp_skid (
    input wire logic CLK,
    input wire logic RST,
    input wire logic IN_VALID,
    output logic IN_READY,
    input asp_pkg::asp_out_s IN_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output asp_pkg::asp_out_s OUT_DATA
);
    import asp_pkg::*;

    asp_out_s mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign IN_READY = (cnt_q != 2'h2);
    assign OUT_VALID = (cnt_q != 2'h0);
    assign OUT_DATA = mem_q[rd_ptr_q];
    assign push = IN_VALID && IN_READY;
    assign pop = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem_q[wr_ptr_q] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ==== hw/asp_core.sv ====
/*
 * Sample post-processor: saturation, offset, gain, clamp, format, averaging.
 * Assumes raw codes arrive one per conversion as a valid pulse, synchronous to CLK.
 */
`timescale 1ns/1ps
module asp_core (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CONVERSION_TRIGGER,
    input wire logic RAW_VALID,
    input asp_pkg::asp_raw_s RAW,
    input wire logic [2:0] OUTPUT_FORMAT_SELECT,
    input wire logic [4:0] AVERAGE_EXPONENT,
    input wire logic [23:0] OFFSET,
    input wire logic [15:0] GAIN,
    input wire logic [31:0] TEST_PATTERN,
    output logic RAW_READY,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [31:0] OUT_WORD,
    output logic OUT_UPDATE,
    output logic BUSY
);
    import asp_pkg::*;

    // ----------------------------------------
    // Pipeline state
    // ----------------------------------------
    typedef enum logic [2:0] {
        ASP_IDLE = 3'b001,
        ASP_WAIT = 3'b010,
        ASP_PUSH = 3'b100
    } asp_state_e;

    asp_state_e state_q;
    asp_state_e state_d;
    logic [23:0] clamp_q;
    logic [7:0] cm_q;
    logic sat_q;
    logic [ASP_ACC_W-1:0] acc_q;
    logic [16:0] cnt_q;
    logic or_q;
    asp_out_s res_q;
    logic buf_ready;
    logic buf_valid;
    asp_out_s buf_data;

    // ----------------------------------------
    // Offset, gain, clamp
    // ----------------------------------------
    logic signed [24:0] sum;
    logic signed [41:0] prod;
    logic signed [26:0] scaled;
    logic [23:0] clamp;

    assign sum = $signed({RAW.diff[23], RAW.diff}) + $signed({OFFSET[23], OFFSET});
    assign prod = $signed({{17{sum[24]}}, sum}) * $signed({26'h000_0000, GAIN});
    assign scaled = prod[ASP_GAIN_SHIFT +: 27];

    always_comb begin
        if (scaled > $signed({{3{1'b0}}, ASP_POS_MAX})) begin
            clamp = ASP_POS_MAX;
        end else if (scaled < $signed({{3{1'b1}}, ASP_NEG_MAX})) begin
            clamp = ASP_NEG_MAX;
        end else begin
            clamp = scaled[23:0];
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    assign RAW_READY = (state_q == ASP_IDLE);
    assign BUSY = (state_q != ASP_IDLE);

    always_comb begin
        case (state_q)
            ASP_IDLE: begin
                state_d = RAW_VALID ? ASP_WAIT : ASP_IDLE;
            end
            ASP_WAIT: begin
                state_d = ASP_PUSH;
            end
            ASP_PUSH: begin
                state_d = buf_ready ? ASP_IDLE : ASP_PUSH;
            end
            default: begin
                state_d = ASP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ASP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            clamp_q <= 24'h00_0000;
            cm_q <= 8'h00;
            sat_q <= 1'b0;
        end else if (RAW_VALID && RAW_READY) begin
            clamp_q <= clamp;
            cm_q <= RAW.cm;
            sat_q <= RAW.sat;
        end
    end

    // ----------------------------------------
    // Block averager
    // ----------------------------------------
    logic avg_on;
    logic [16:0] blk_len;
    logic blk_end;
    logic [ASP_ACC_W-1:0] acc_sum;
    logic [ASP_ACC_W-1:0] acc_shr;
    logic or_now;

    assign avg_on = (OUTPUT_FORMAT_SELECT == ASP_FMT_AVG) && (AVERAGE_EXPONENT != ASP_AVG_RST)
        && (AVERAGE_EXPONENT <= ASP_AVG_MAX);
    assign blk_len = 17'h0_0001 << AVERAGE_EXPONENT;
    assign blk_end = (cnt_q + 17'h0_0001 == blk_len);
    assign acc_sum = acc_q + {{(ASP_ACC_W-24){clamp_q[23]}}, clamp_q};
    assign acc_shr = $unsigned($signed(acc_sum) >>> AVERAGE_EXPONENT) << 6;
    assign or_now = or_q | sat_q;

    always_ff @(posedge CLK) begin
        if (RST || !avg_on) begin
            acc_q <= '0;
            cnt_q <= ASP_CNT_RST;
            or_q <= 1'b0;
        end else if (state_q == ASP_WAIT) begin
            if (blk_end) begin
                acc_q <= '0;
                cnt_q <= ASP_CNT_RST;
                or_q <= 1'b0;
            end else begin
                acc_q <= acc_sum;
                cnt_q <= cnt_q + 17'h0_0001;
                or_q <= or_now;
            end
        end
    end

    // ----------------------------------------
    // Output formatting
    // ----------------------------------------
    logic [29:0] avg_hold_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            avg_hold_q <= 30'h0000_0000;
        end else if (state_q == ASP_WAIT && avg_on && blk_end) begin
            avg_hold_q <= acc_shr[29:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            res_q <= '0;
        end else if (state_q == ASP_WAIT) begin
            res_q.update <= avg_on && blk_end;
            case (OUTPUT_FORMAT_SELECT)
                ASP_FMT_D16CM: begin
                    res_q.word <= {8'h00, clamp_q[23:8], cm_q};
                end
                ASP_FMT_D24CM: begin
                    res_q.word <= {clamp_q, cm_q};
                end
                ASP_FMT_AVG: begin
                    if (avg_on) begin
                        res_q.word <= {blk_end ? acc_shr[29:0] : avg_hold_q, or_now, blk_end};
                    end else begin
                        res_q.word <= {8'h00, clamp_q};
                    end
                end
                ASP_FMT_TEST: begin
                    res_q.word <= TEST_PATTERN;
                end
                default: begin
                    res_q.word <= {8'h00, clamp_q};
                end
            endcase
        end
    end

    // ----------------------------------------
    // Output buffer
    // ----------------------------------------
    asp_skid u_skid (
        .CLK(CLK),
        .RST(RST),
        .IN_VALID(state_q == ASP_PUSH),
        .IN_READY(buf_ready),
        .IN_DATA(res_q),
        .OUT_VALID(buf_valid),
        .OUT_READY(OUT_READY),
        .OUT_DATA(buf_data)
    );

    assign OUT_VALID = buf_valid;
    assign OUT_WORD = buf_data.word;
    assign OUT_UPDATE = buf_data.update;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_clamp_pos;
        @(posedge CLK) disable iff (RST)
        (scaled > $signed({{3{1'b0}}, ASP_POS_MAX})) |-> clamp == ASP_POS_MAX;
    endproperty
    a_clamp_pos: assert property (p_clamp_pos) else $error("positive clamp wrong");

    property p_clamp_neg;
        @(posedge CLK) disable iff (RST)
        (scaled < $signed({{3{1'b1}}, ASP_NEG_MAX})) |-> clamp == ASP_NEG_MAX;
    endproperty
    a_clamp_neg: assert property (p_clamp_neg) else $error("negative clamp wrong");

    property p_cm_pass;
        @(posedge CLK) disable iff (RST)
        (RAW_VALID && RAW_READY) |=> cm_q == $past(RAW.cm);
    endproperty
    a_cm_pass: assert property (p_cm_pass) else $error("cm altered");

    property p_unity;
        @(posedge CLK) disable iff (RST)
        (GAIN == ASP_GAIN_RST && OFFSET == ASP_OFFSET_RST) |-> clamp == RAW.diff;
    endproperty
    a_unity: assert property (p_unity) else $error("unity path altered code");

    property p_test;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && OUTPUT_FORMAT_SELECT == ASP_FMT_TEST) |=> res_q.word == $past(TEST_PATTERN);
    endproperty
    a_test: assert property (p_test) else $error("test pattern missing");

    property p_sync;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && avg_on) |=> res_q.word[0] == $past(blk_end);
    endproperty
    a_sync: assert property (p_sync) else $error("sync bit wrong");

    property p_or;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && avg_on && sat_q) |=> res_q.word[1];
    endproperty
    a_or: assert property (p_or) else $error("overrange not set");

    property p_clear;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && avg_on && blk_end) |=> acc_q == '0 && cnt_q == ASP_CNT_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("accumulator not cleared");

    property p_latch;
        @(posedge CLK) disable iff (RST)
        (RAW_VALID && RAW_READY) |-> ##2 state_q == ASP_PUSH;
    endproperty
    a_latch: assert property (p_latch) else $error("word not offered");

    property p_sat_hold;
        @(posedge CLK) disable iff (RST)
        (RAW_VALID && RAW_READY) |=> sat_q == $past(RAW.sat);
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("saturation flag lost");

    property p_clamp_mid;
        @(posedge CLK) disable iff (RST)
        (scaled <= $signed({{3{1'b0}}, ASP_POS_MAX}) && scaled >= $signed({{3{1'b1}}, ASP_NEG_MAX}))
        |-> clamp == scaled[23:0];
    endproperty
    a_clamp_mid: assert property (p_clamp_mid) else $error("in-range value altered");

    property p_fmt0;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && OUTPUT_FORMAT_SELECT == ASP_FMT_DIFF24)
        |=> res_q.word == {8'h00, $past(clamp_q)};
    endproperty
    a_fmt0: assert property (p_fmt0) else $error("plain format word wrong");

    property p_d24cm;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && OUTPUT_FORMAT_SELECT == ASP_FMT_D24CM)
        |=> res_q.word == {$past(clamp_q), $past(cm_q)};
    endproperty
    a_d24cm: assert property (p_d24cm) else $error("24-bit cm word wrong");

    property p_d16cm;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && OUTPUT_FORMAT_SELECT == ASP_FMT_D16CM)
        |=> res_q.word == {8'h00, $past(clamp_q[23:8]), $past(cm_q)};
    endproperty
    a_d16cm: assert property (p_d16cm) else $error("16-bit cm word wrong");

    property p_low_zero;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && avg_on && blk_end) |=> res_q.word[7:2] == 6'h00;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("average not scaled");

    property p_upd_rate;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && !(avg_on && blk_end)) |=> !res_q.update;
    endproperty
    a_upd_rate: assert property (p_upd_rate) else $error("update outside block end");

    property p_sync_upd;
        @(posedge CLK) disable iff (RST)
        (state_q == ASP_WAIT && avg_on) |=> res_q.update == res_q.word[0];
    endproperty
    a_sync_upd: assert property (p_sync_upd) else $error("update and sync differ");

    property p_refuse;
        @(posedge CLK) disable iff (RST)
        (RAW_VALID && RAW_READY) |=> !RAW_READY ##1 !RAW_READY;
    endproperty
    a_refuse: assert property (p_refuse) else $error("sample taken too soon");

    property p_out_hold;
        @(posedge CLK) disable iff (RST)
        (OUT_VALID && !OUT_READY) |=> OUT_VALID && $stable(OUT_WORD) && $stable(OUT_UPDATE);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("stalled word changed");
endmodule

// ==== verif/asp_host_sink.sv ====
/*
 * Host-side reader of the output register: takes words, may stall.
 * Assumes one clock and synchronous active-high reset shared with the core.
 */
`timescale 1ns/1ps
module asp_host_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [31:0] out_word,
    input wire logic out_update,
    output logic out_ready
);
    logic [32:0] got_q[$];

    // ----------------------------------------
    // Word capture
    // ----------------------------------------
    assign out_ready = !stall;
    always @(posedge clk) begin
        if (rst) begin
            got_q.delete();
        end else if (out_valid && out_ready) begin
            got_q.push_back({out_update, out_word});
        end
    end
endmodule

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the sample post-processor.
 * Assumes the host sink model and the core on one 100 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (a), (b)); end end
module tb;
    import asp_pkg::*;
    logic clk, rst, raw_valid, raw_ready, out_valid, out_ready, out_update, busy, stall;
    asp_raw_s raw;
    logic [2:0] fmt;
    logic [4:0] avg_n;
    logic [23:0] offset;
    logic [15:0] gain;
    logic [31:0] pattern, out_word;
    int num_errors = 0;
    int n_tests = 0;

    asp_core DUT (.CLK(clk), .RST(rst), .CONVERSION_TRIGGER(1'b0), .RAW_VALID(raw_valid), .RAW(raw),
        .OUTPUT_FORMAT_SELECT(fmt), .AVERAGE_EXPONENT(avg_n), .OFFSET(offset), .GAIN(gain),
        .TEST_PATTERN(pattern), .RAW_READY(raw_ready), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_WORD(out_word), .OUT_UPDATE(out_update), .BUSY(busy));
    asp_host_sink host (.clk(clk), .rst(rst), .stall(stall), .out_valid(out_valid), .out_word(out_word),
        .out_update(out_update), .out_ready(out_ready));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [23:0] proc(input logic [23:0] d, input logic [23:0] o, input logic [15:0] g);
        longint v;
        v = ((longint'($signed(d)) + longint'($signed(o))) * longint'(g)) >>> 15;
        if (v > longint'(ASP_POS_MAX)) return ASP_POS_MAX;
        if (v < -longint'(ASP_NEG_MAX)) return ASP_NEG_MAX;
        return v[23:0];
    endfunction

    task automatic send(input logic [23:0] d, input logic [7:0] c, input logic s);
        int i;
        raw = {d, c, s};
        raw_valid = 1'b1;
        for (i = 0; i < 60 && !raw_ready; i++) @(negedge clk);
        `CHK(raw_ready, 1'b1)
        @(negedge clk);
        raw_valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic get(input logic [32:0] exp, input logic [32:0] mask);
        int i;
        logic [32:0] got;
        for (i = 0; i < 60 && host.got_q.size() == 0; i++) @(negedge clk);
        `CHK(host.got_q.size() != 0, 1'b1)
        got = (host.got_q.size() != 0) ? host.got_q.pop_front() : ~exp;
        `CHK(got & mask, exp & mask)
    endtask

    task automatic avg_block(input logic [4:0] n, input logic [23:0] d, input logic [23:0] st, input logic s);
        int i;
        longint sum;
        logic [23:0] x;
        sum = 0;
        avg_n = n;
        for (i = 0; i < (1 << n); i++) begin
            x = d + 24'(st * i);
            sum += longint'($signed(x));
            send(x, 8'h00, s && i == 0);
            if (i < (1 << n) - 1) get({31'h0000_0000, s, 1'b0}, 33'h1_0000_0003);
        end
        sum = sum >>> n;
        get({1'b1, sum[23:0], 6'h00, s, 1'b1}, 33'h1_FFFF_FFFF);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_scale();
        logic [63:0] tbl[7];
        int i;
        tbl = '{{24'h7F_FFF0, 24'h00_0100, 16'h8000}, {24'h80_0010, 24'hFF_FF00, 16'h8000},
            {24'h40_0000, 24'h00_0000, 16'hFFFF}, {24'h60_0000, 24'h00_0000, 16'hC000},
            {24'h00_0100, 24'h00_0100, 16'h4000}, {24'h7F_FFFF, 24'h00_0001, 16'h4000},
            {24'hFF_FFFF, 24'h00_0000, 16'h4000}};
        fmt = ASP_FMT_D24CM;
        for (i = 0; i < 7; i++) begin
            {offset, gain} = tbl[i][39:0];
            send(tbl[i][63:40], 8'(8'hF0 + i), 1'b0);
            get({1'b0, proc(tbl[i][63:40], offset, gain), 8'(8'hF0 + i)}, 33'h0_FFFF_FFFF);
        end
    endtask

    task automatic t_formats();
        logic [2:0] f[6];
        logic [23:0] p;
        logic [31:0] e;
        int i;
        f = '{ASP_FMT_DIFF24, ASP_FMT_D16CM, ASP_FMT_D24CM, ASP_FMT_TEST, 3'h5, ASP_FMT_AVG};
        offset = 24'h00_0010;
        gain = ASP_GAIN_RST;
        pattern = 32'hC3A5_1E69;
        p = proc(24'h81_2345, offset, gain);
        for (i = 0; i < 6; i++) begin
            fmt = f[i];
            e = (f[i] == ASP_FMT_D16CM) ? {8'h00, p[23:8], 8'hA5} : (f[i] == ASP_FMT_D24CM) ? {p, 8'hA5} :
                (f[i] == ASP_FMT_TEST) ? pattern : {8'h00, p};
            send(24'h81_2345, 8'hA5, 1'b0);
            get({1'b0, e}, 33'h1_FFFF_FFFF);
        end
    endtask

    task automatic t_buffer();
        int i;
        fmt = ASP_FMT_D24CM;
        offset = ASP_OFFSET_RST;
        gain = ASP_GAIN_RST;
        stall = 1'b1;
        for (i = 0; i < 3; i++) send(24'(24'h00_0100 + i), 8'(i), 1'b0);
        repeat (10) @(negedge clk);
        `CHK(out_valid, 1'b1)
        `CHK(raw_ready, 1'b0)
        stall = 1'b0;
        for (i = 0; i < 3; i++) get({1'b0, 24'(24'h00_0100 + i), 8'(i)}, 33'h0_FFFF_FFFF);
    endtask

    task automatic test_done();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        num_errors++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        raw_valid = 1'b0;
        raw = '0;
        stall = 1'b0;
        fmt = ASP_FMT_DIFF24;
        avg_n = ASP_AVG_RST;
        offset = ASP_OFFSET_RST;
        gain = ASP_GAIN_RST;
        pattern = ASP_PATTERN_RST;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        `CHK({raw_ready, busy, out_valid}, 3'b100)
        t_scale();
        t_formats();
        t_buffer();
        fmt = ASP_FMT_AVG;
        offset = ASP_OFFSET_RST;
        gain = ASP_GAIN_RST;
        avg_block(5'h02, 24'h00_0064, 24'h00_0001, 1'b0);
        avg_block(5'h01, 24'hFF_CFC7, 24'h00_0000, 1'b0);
        avg_block(5'h02, 24'h7F_FFFF, 24'h00_0000, 1'b1);
        avg_block(5'h02, 24'h00_0000, 24'h00_0000, 1'b0);
        test_done();
    end
endmodule
